// [logic/iosr_top.sv]
// Purpose: builds i/o sample records on query, interval or line change
// Assumes: axi4-lite slave, one 20 MHz clock, analog results already converted
// Notes:
// Functional notes
// - mask bits 0-6: lines 0-6
// - mask bits 7-12: lines 7-12 in order
// - two-byte digital mask follows count
// - record opens with count byte one
// - analog mask bits 0-3 flag channels
// - state bytes only when digital enabled
// - two bytes per analog channel, ascending
// - pin config codes 0,3,4,5 honoured; code 2 on lines 0-3 only
// - text query: one field per CR line
// - api query: response frame carries record
// - interval zero disables periodic sampling
// - nonzero interval samples every N ms
// - remote records go to dest address
// - api mode forwards received records, else drop
// - sleep: sample until wake hold expires
// - watch mask selects monitored lines
// - watched change sends record at once
// - change samples immediately, off schedule

`timescale 1ns/10ps
`default_nettype none

module iosr_top #(
  parameter int CYC_PER_MS = iosr_pkg::CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [iosr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [iosr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [iosr_pkg::NUM_DIO-1:0] line_in,
  output logic [iosr_pkg::NUM_DIO-1:0] line_out,
  output logic [iosr_pkg::NUM_DIO-1:0] line_oe_n,
  input wire logic [iosr_pkg::NUM_AN*iosr_pkg::AN_W-1:0] analog_result,
  input wire logic wake_req,
  output logic sleep_ok,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [7:0] rec_data,
  output logic rec_last,
  output logic [1:0] rec_dest,
  output logic [63:0] rec_addr,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic fwd_valid,
  input wire logic fwd_ready,
  output logic [7:0] fwd_data,
  output logic fwd_last
);
  localparam int ND = iosr_pkg::NUM_DIO;

  typedef enum logic [1:0] {S_IDLE, S_HDR, S_BODY} iosr_state_t;

  iosr_state_t st_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [iosr_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic api_reg, sleep_en_reg, query_wr;
  logic [15:0] ival_reg, wake_reg, ival_cnt_reg, hold_cnt_reg;
  logic [ND-1:0] watch_reg, prev_reg, line_st, dmask, drive_hi, drive_en;
  logic [31:0] dh_reg, dl_reg;
  logic [ND*iosr_pkg::PCFG_W-1:0] pcfg_reg;
  logic [iosr_pkg::NUM_AN-1:0] amask;
  logic wake_st, wake_prev_reg, awake_reg, ms_tick;
  logic qry_pend_reg, chg_pend_reg, per_pend_reg, chg_hit, per_fire;
  logic take_q, take_r, advance, wr_go;
  logic [7:0] mem_reg [iosr_pkg::REC_MAX];
  logic [7:0] bld_mem [iosr_pkg::REC_MAX];
  logic [iosr_pkg::REC_MAX-1:0] fend_reg, bld_fend;
  logic [3:0] len_reg, bld_len, idx_reg;
  logic [2:0] ph_reg;
  iosr_pkg::iosr_dest_t dest_reg;
  logic [63:0] addr_reg;

  iosr_sync #(.W(ND + 1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in({wake_req, line_in}),
    .d_stable({wake_st, line_st})
  );

  iosr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(ms_tick)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8+:8] = nw[b*8+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? (iosr_pkg::CHAR_ZERO + {4'h0, n}) : (iosr_pkg::CHAR_HEX_AF + {4'h0, n});
  endfunction

  // ---------------- axi4-lite write path
  assign awready = !aw_hold_reg;
  assign wready = !w_hold_reg;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= iosr_pkg::ZERO_RST;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= iosr_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (wr_go) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (aw_addr_reg <= iosr_pkg::OFS_STATUS && aw_addr_reg[1:0] == 2'h0) ?
                 iosr_pkg::RESP_OKAY : iosr_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // a query write only pulses; it is not stored
  assign query_wr = wr_go && aw_addr_reg == iosr_pkg::OFS_CTRL && w_strb_reg[0] &&
                    w_data_reg[iosr_pkg::CTRL_QUERY_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      api_reg <= 1'b0;
      sleep_en_reg <= 1'b0;
      ival_reg <= iosr_pkg::IVAL_RST;
      watch_reg <= '0;
      dh_reg <= iosr_pkg::ZERO_RST;
      dl_reg <= iosr_pkg::ZERO_RST;
      wake_reg <= iosr_pkg::WAKE_RST;
      pcfg_reg <= '0;
    end else if (wr_go) begin
      if (aw_addr_reg == iosr_pkg::OFS_CTRL) begin
        if (w_strb_reg[0]) begin
          api_reg <= w_data_reg[iosr_pkg::CTRL_API_BIT];
          sleep_en_reg <= w_data_reg[iosr_pkg::CTRL_SLEEP_BIT];
        end
      end else if (aw_addr_reg == iosr_pkg::OFS_IVAL) begin
        ival_reg <= 16'(merge({16'h0000, ival_reg}, w_data_reg, w_strb_reg));
      end else if (aw_addr_reg == iosr_pkg::OFS_WATCH) begin
        watch_reg <= ND'(merge({19'h0, watch_reg}, w_data_reg, w_strb_reg));
      end else if (aw_addr_reg == iosr_pkg::OFS_DADDR_H) begin
        dh_reg <= merge(dh_reg, w_data_reg, w_strb_reg);
      end else if (aw_addr_reg == iosr_pkg::OFS_DADDR_L) begin
        dl_reg <= merge(dl_reg, w_data_reg, w_strb_reg);
      end else if (aw_addr_reg == iosr_pkg::OFS_WAKE) begin
        wake_reg <= 16'(merge({16'h0000, wake_reg}, w_data_reg, w_strb_reg));
      end else if (aw_addr_reg == iosr_pkg::OFS_PCFG_LO) begin
        pcfg_reg[29:0] <= 30'(merge({2'h0, pcfg_reg[29:0]}, w_data_reg, w_strb_reg));
      end else if (aw_addr_reg == iosr_pkg::OFS_PCFG_HI) begin
        pcfg_reg[38:30] <= 9'(merge({23'h0, pcfg_reg[38:30]}, w_data_reg, w_strb_reg));
      end
    end
  end

  // ---------------- axi4-lite read path
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= iosr_pkg::ZERO_RST;
      rresp <= iosr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= iosr_pkg::RESP_OKAY;
      if (araddr == iosr_pkg::OFS_CTRL) begin
        rdata <= {29'h0, sleep_en_reg, api_reg, 1'b0};
      end else if (araddr == iosr_pkg::OFS_IVAL) begin
        rdata <= {16'h0000, ival_reg};
      end else if (araddr == iosr_pkg::OFS_WATCH) begin
        rdata <= {19'h0, watch_reg};
      end else if (araddr == iosr_pkg::OFS_DADDR_H) begin
        rdata <= dh_reg;
      end else if (araddr == iosr_pkg::OFS_DADDR_L) begin
        rdata <= dl_reg;
      end else if (araddr == iosr_pkg::OFS_WAKE) begin
        rdata <= {16'h0000, wake_reg};
      end else if (araddr == iosr_pkg::OFS_PCFG_LO) begin
        rdata <= {2'h0, pcfg_reg[29:0]};
      end else if (araddr == iosr_pkg::OFS_PCFG_HI) begin
        rdata <= {23'h0, pcfg_reg[38:30]};
      end else if (araddr == iosr_pkg::OFS_STATUS) begin
        rdata <= {3'h0, line_st, 14'h0, awake_reg, st_reg != S_IDLE};
      end else begin
        rdata <= iosr_pkg::ZERO_RST;
        rresp <= iosr_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- pin configuration, one entry per line
  genvar gi;
  for (gi = 0; gi < ND; gi++) begin : g_pin
    logic [2:0] cfg;
    assign cfg = pcfg_reg[gi*iosr_pkg::PCFG_W+:iosr_pkg::PCFG_W];
    assign dmask[gi] = cfg == iosr_pkg::PCFG_MON;
    assign drive_en[gi] = cfg == iosr_pkg::PCFG_OUT_LO || cfg == iosr_pkg::PCFG_OUT_HI;
    assign drive_hi[gi] = cfg == iosr_pkg::PCFG_OUT_HI;
    if (gi < iosr_pkg::NUM_AN) begin : g_an
      assign amask[gi] = cfg == iosr_pkg::PCFG_ANALOG;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_out <= '0;
      line_oe_n <= '1;
    end else begin
      line_out <= drive_hi;
      line_oe_n <= ~drive_en;
    end
  end

  // ---------------- wake window while sleep is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_prev_reg <= 1'b0;
      awake_reg <= 1'b1;
      hold_cnt_reg <= 16'h0000;
    end else begin
      wake_prev_reg <= wake_st;
      if (!sleep_en_reg) begin
        awake_reg <= 1'b1;
        hold_cnt_reg <= 16'h0000;
      end else if (wake_st && !wake_prev_reg) begin
        awake_reg <= 1'b1;
        hold_cnt_reg <= 16'h0000;
      end else if (awake_reg && ms_tick) begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        if (hold_cnt_reg + 16'h0001 >= wake_reg) begin
          awake_reg <= 1'b0;
        end
      end
    end
  end

  assign sleep_ok = sleep_en_reg && !awake_reg;

  // ---------------- periodic and change triggers
  assign per_fire = ms_tick && awake_reg && ival_reg != 16'h0000 && ival_cnt_reg + 16'h0001 >= ival_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || ival_reg == 16'h0000 || !awake_reg) begin
      ival_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      ival_cnt_reg <= per_fire ? 16'h0000 : ival_cnt_reg + 16'h0001;
    end
  end

  // compare settled line states with last cycle's copy
  assign chg_hit = |((line_st ^ prev_reg) & watch_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= line_st;
    end
  end

  assign take_q = st_reg == S_IDLE && qry_pend_reg;
  assign take_r = st_reg == S_IDLE && !qry_pend_reg && (chg_pend_reg || per_pend_reg);

  // a new event in the same cycle as the take is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qry_pend_reg <= 1'b0;
      chg_pend_reg <= 1'b0;
      per_pend_reg <= 1'b0;
    end else begin
      qry_pend_reg <= (qry_pend_reg && !take_q) || query_wr;
      chg_pend_reg <= (chg_pend_reg && !take_r) || chg_hit;
      per_pend_reg <= (per_pend_reg && !take_r) || per_fire;
    end
  end

  // ---------------- record assembly from live state
  always_comb begin
    logic [3:0] p;
    p = 4'h4;
    bld_fend = '0;
    for (int k = 0; k < iosr_pkg::REC_MAX; k++) begin
      bld_mem[k] = 8'h00;
    end
    bld_mem[0] = iosr_pkg::SAMPLE_SETS;
    bld_mem[1] = {3'h0, dmask[12:8]};
    bld_mem[2] = dmask[7:0];
    bld_mem[3] = {4'h0, amask};
    bld_fend[0] = 1'b1;
    bld_fend[2] = 1'b1;
    bld_fend[3] = 1'b1;
    if (dmask != '0) begin
      bld_mem[4] = {3'h0, line_st[12:8]};
      bld_mem[5] = line_st[7:0];
      bld_fend[5] = 1'b1;
      p = 4'h6;
    end
    for (int c = 0; c < iosr_pkg::NUM_AN; c++) begin
      if (amask[c]) begin
        bld_mem[p] = analog_result[c*iosr_pkg::AN_W+8+:8];
        bld_mem[p+4'h1] = analog_result[c*iosr_pkg::AN_W+:8];
        bld_fend[p+4'h1] = 1'b1;
        p = p + 4'h2;
      end
    end
    bld_len = p;
  end

  // ---------------- emitter
  assign advance = !rec_valid || rec_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= S_IDLE;
      idx_reg <= 4'h0;
      ph_reg <= 3'h0;
      len_reg <= 4'h0;
      fend_reg <= '0;
      rec_dest <= iosr_pkg::DEST_HOST_TEXT;
      rec_addr <= 64'h0000_0000_0000_0000;
      dest_reg <= iosr_pkg::DEST_HOST_TEXT;
      addr_reg <= 64'h0000_0000_0000_0000;
      rec_valid <= 1'b0;
      rec_data <= 8'h00;
      rec_last <= 1'b0;
      for (int k = 0; k < iosr_pkg::REC_MAX; k++) begin
        mem_reg[k] <= 8'h00;
      end
    end else begin
      if (rec_valid && rec_ready) begin
        rec_valid <= 1'b0;
      end
      case (st_reg)
        S_IDLE: begin
          if (take_q || take_r) begin
            mem_reg <= bld_mem;
            fend_reg <= bld_fend;
            len_reg <= bld_len;
            idx_reg <= 4'h0;
            ph_reg <= 3'h0;
            // a stalled last byte keeps its tags; the new ones ride with the next byte
            if (take_r) begin
              dest_reg <= iosr_pkg::DEST_REMOTE;
              addr_reg <= {dh_reg, dl_reg};
              st_reg <= S_BODY;
            end else if (api_reg) begin
              dest_reg <= iosr_pkg::DEST_HOST_API;
              addr_reg <= 64'h0000_0000_0000_0000;
              st_reg <= S_HDR;
            end else begin
              dest_reg <= iosr_pkg::DEST_HOST_TEXT;
              addr_reg <= 64'h0000_0000_0000_0000;
              st_reg <= S_BODY;
            end
          end
        end
        S_HDR: begin
          if (advance) begin
            rec_valid <= 1'b1;
            rec_data <= iosr_pkg::API_RESP_TYPE;
            rec_last <= 1'b0;
            rec_dest <= dest_reg;
            rec_addr <= addr_reg;
            st_reg <= S_BODY;
          end
        end
        S_BODY: begin
          if (advance) begin
            rec_valid <= 1'b1;
            rec_last <= 1'b0;
            rec_dest <= dest_reg;
            rec_addr <= addr_reg;
            if (dest_reg != iosr_pkg::DEST_HOST_TEXT) begin
              rec_data <= mem_reg[idx_reg];
              idx_reg <= idx_reg + 4'h1;
              if (idx_reg + 4'h1 == len_reg) begin
                rec_last <= 1'b1;
                st_reg <= S_IDLE;
              end
            end else begin
              case (ph_reg)
                3'h0: begin
                  rec_data <= iosr_pkg::CHAR_ZERO;
                  ph_reg <= 3'h1;
                end
                3'h1: begin
                  rec_data <= iosr_pkg::CHAR_X;
                  ph_reg <= 3'h2;
                end
                3'h2: begin
                  rec_data <= hexc(mem_reg[idx_reg][7:4]);
                  ph_reg <= 3'h3;
                end
                3'h3: begin
                  rec_data <= hexc(mem_reg[idx_reg][3:0]);
                  idx_reg <= idx_reg + 4'h1;
                  ph_reg <= fend_reg[idx_reg] ? 3'h4 : 3'h2;
                end
                default: begin
                  rec_data <= iosr_pkg::CHAR_CR;
                  ph_reg <= 3'h0;
                  if (idx_reg == len_reg) begin
                    rec_last <= 1'b1;
                    st_reg <= S_IDLE;
                  end
                end
              endcase
            end
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------- received records toward the host
  assign rx_ready = api_reg ? (!fwd_valid || fwd_ready) : 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_valid <= 1'b0;
      fwd_data <= 8'h00;
      fwd_last <= 1'b0;
    end else if (rx_valid && rx_ready && api_reg) begin
      fwd_valid <= 1'b1;
      fwd_data <= rx_data;
      fwd_last <= rx_last;
    end else if (fwd_ready) begin
      fwd_valid <= 1'b0;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_COUNT_ONE: assert property (st_reg != S_IDLE |-> mem_reg[0] == iosr_pkg::SAMPLE_SETS)
    else $error("record does not open with one sample set");
  AST_DMASK: assert property ((take_q || take_r) |=> {mem_reg[1], mem_reg[2]} == {3'h0, $past(dmask)})
    else $error("digital mask bytes wrong");
  AST_AMASK: assert property ((take_q || take_r) |=> mem_reg[3] == {4'h0, $past(amask)})
    else $error("analog mask byte wrong");
  AST_LEN: assert property ((take_q || take_r) |=> len_reg == 4'h4 + (($past(dmask) != '0) ? 4'h2 : 4'h0)
                            + {$countones($past(amask)), 1'b0})
    else $error("record length wrong");
  AST_IVAL_OFF: assert property (ival_reg == 16'h0000 |-> !per_fire)
    else $error("periodic sample with zero interval");
  AST_IVAL_TICK: assert property (per_fire |-> ms_tick ##1 per_pend_reg)
    else $error("periodic fire not on a tick");
  AST_CHG: assert property ((chg_hit && st_reg == S_IDLE && !qry_pend_reg) |-> ##[1:2] st_reg != S_IDLE)
    else $error("watched change did not start a record");
  AST_DEST: assert property (take_r |=> dest_reg == iosr_pkg::DEST_REMOTE
                             && addr_reg == $past({dh_reg, dl_reg}))
    else $error("remote record not addressed to destination");
  AST_CR_END: assert property ((rec_valid && rec_last && rec_dest == iosr_pkg::DEST_HOST_TEXT)
                               |-> rec_data == iosr_pkg::CHAR_CR)
    else $error("text record does not end with carriage return");
  AST_DROP: assert property ((!api_reg && !fwd_valid) |=> !fwd_valid)
    else $error("record forwarded outside api mode");
  AST_SLEEP: assert property ((sleep_en_reg && !awake_reg) |-> !per_fire)
    else $error("periodic sample while asleep");
endmodule

`default_nettype wire

// [logic/iosr_pkg.sv]
// Purpose: shared constants for the i/o sample reporter
// Assumes: 20 MHz aclk, 32-bit axi4-lite register bus
// Notes: register offsets are byte addresses

package iosr_pkg;
  localparam int NUM_DIO = 13;
  localparam int NUM_AN = 4;
  localparam int AN_W = 16;
  localparam int REC_MAX = 14;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IVAL = 8'h04;
  localparam logic [7:0] OFS_WATCH = 8'h08;
  localparam logic [7:0] OFS_DADDR_H = 8'h0C;
  localparam logic [7:0] OFS_DADDR_L = 8'h10;
  localparam logic [7:0] OFS_WAKE = 8'h14;
  localparam logic [7:0] OFS_PCFG_LO = 8'h18;
  localparam logic [7:0] OFS_PCFG_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // control, status and pin configuration fields
  localparam int CTRL_QUERY_BIT = 0;
  localparam int CTRL_API_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_AWAKE_BIT = 1;
  localparam int STAT_LINES_LSB = 16;
  localparam int PCFG_W = 3;
  localparam int PCFG_LO_PINS = 10;
  // pin configuration codes
  localparam logic [2:0] PCFG_UNMON = 3'h0;
  localparam logic [2:0] PCFG_ANALOG = 3'h2;
  localparam logic [2:0] PCFG_MON = 3'h3;
  localparam logic [2:0] PCFG_OUT_LO = 3'h4;
  localparam logic [2:0] PCFG_OUT_HI = 3'h5;
  // reset values
  localparam logic [15:0] IVAL_RST = 16'h0000;
  localparam logic [15:0] WAKE_RST = 16'h1388;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // record bytes and axi4-lite response codes
  localparam logic [7:0] SAMPLE_SETS = 8'h01;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_X = 8'h78;
  localparam logic [7:0] CHAR_HEX_AF = 8'h37;
  localparam logic [7:0] API_RESP_TYPE = 8'h88;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;

  typedef enum logic [1:0] {DEST_HOST_TEXT, DEST_HOST_API, DEST_REMOTE} iosr_dest_t;
endpackage

// [logic/iosr_sync.sv]
// Purpose: three-stage input synchroniser per line
// Assumes: inputs are asynchronous to aclk
// Notes: output moves only when stages two and three agree

`timescale 1ns/10ps
`default_nettype none

module iosr_sync #(
  parameter int W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_stable
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
        d_stable[i] <= 1'b0;
      end else begin
        s1_reg[i] <= d_in[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          d_stable[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

`default_nettype wire

// [logic/iosr_ms_timer.sv]
// Purpose: one-cycle tick once per millisecond
// Assumes: CYC_PER_MS clock cycles per millisecond
// Notes: shorten CYC_PER_MS in simulation

`timescale 1ns/10ps
`default_nettype none

module iosr_ms_timer #(
  parameter int CYC_PER_MS = iosr_pkg::CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_reg == 32'(CYC_PER_MS - 1)) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// [bench/iosr_partner.sv]
// Purpose: far side: record sink, rx source
// Assumes: random stalls on both readies
// Notes: rx data inverted once released
`timescale 1ns/10ps
`default_nettype none
module iosr_partner (
  input wire logic aclk,
  input wire logic rec_valid,
  output logic rec_ready,
  input wire logic [7:0] rec_data,
  input wire logic rec_last,
  input wire logic [1:0] rec_dest,
  input wire logic [63:0] rec_addr,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic fwd_valid,
  output logic fwd_ready,
  input wire logic [7:0] fwd_data,
  input wire logic fwd_last
);
  int ps = 52941;
  int nl = 0;
  logic [31:0] r;
  logic [10:0] rq[$];
  logic [8:0] fq[$];
  logic [63:0] ad;
  initial begin
    rec_ready = 0;
    fwd_ready = 0;
    rx_valid = 0;
    rx_data = 8'hA5;
    rx_last = 0;
  end
  always @(posedge aclk) begin
    r = $random(ps);
    if (rec_valid && rec_ready) begin
      // state bytes kept raw, bits outside the mask carry no meaning
      rq.push_back({rec_dest, rec_last, rec_data});
      nl += rec_last;
      ad = rec_addr;
    end
    if (fwd_valid && fwd_ready)
      fq.push_back({fwd_last, fwd_data});
    rec_ready <= r[1:0] != 2'h0;
    fwd_ready <= r[3:2] != 2'h0;
  end
  task automatic send(input logic [7:0] d);
    rx_valid <= 1;
    rx_data <= d;
    rx_last <= 1;
    do @(posedge aclk); while (rx_ready !== 1);
    rx_valid <= 0;
    rx_data <= ~d;
    rx_last <= 0;
  endtask
endmodule
`default_nettype wire

// [bench/io_sample_reporter_tb_top.sv]
// Purpose: self-checking bench for the sample reporter
// Assumes: ms tick shortened to 20 cycles
// Notes: expected records built from the layout
`timescale 1ns/10ps
`default_nettype none
module io_sample_reporter_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req;
  logic awready, wready, bvalid, arready, rvalid, sleep_ok, rec_valid, rec_ready, rec_last;
  logic rx_valid, rx_ready, rx_last, fwd_valid, fwd_ready, fwd_last;
  logic [7:0] awaddr, araddr, rec_data, rx_data, fwd_data;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rec_dest;
  logic [12:0] line_in, line_out, line_oe_n;
  logic [63:0] analog_result, rec_addr;
  logic [7:0] eq[$];
  string txt = "0x01\0150x0000\0150x00\015";
  int seed = 52941;
  int err_count = 0;
  int tests_run = 0;
  iosr_top #(.CYC_PER_MS(20)) i_dut (.*);
  iosr_partner p (.*);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1) awvalid <= 0;
      if (wready === 1) wvalid <= 0;
    end while (awvalid || wvalid);
    while (bvalid !== 1) @(posedge aclk);
    bready <= 0;
    check(bresp, iosr_pkg::RESP_OKAY);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1);
    v = rdata;
    rready <= 0;
    check(rresp, er);
    @(posedge aclk);
  endtask
  // expected record from mask settings and the held inputs
  task automatic mk(input logic [12:0] dm, input logic [3:0] am, input logic api);
    eq = {};
    if (api) eq.push_back(iosr_pkg::API_RESP_TYPE);
    eq.push_back(iosr_pkg::SAMPLE_SETS);
    eq.push_back({3'h0, dm[12:8]});
    eq.push_back(dm[7:0]);
    eq.push_back({4'h0, am});
    if (dm != 0) begin
      eq.push_back({3'h0, line_in[12:8]});
      eq.push_back(line_in[7:0]);
    end
    for (int c = 0; c < 4; c++) begin
      if (am[c]) begin
        eq.push_back(analog_result[16*c+8 +: 8]);
        eq.push_back(analog_result[16*c +: 8]);
      end
    end
  endtask
  task automatic cmp(input logic [1:0] dst);
    int t;
    t = 0;
    while (p.nl == 0 && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    if (t == 3000) err_count++;
    p.nl--;
    foreach (eq[i])
      check(p.rq.pop_front(), {dst, i == eq.size() - 1, eq[i]});
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wake_req, awaddr, araddr, wdata} = 0;
    wstrb = 4'hF;
    line_in = 13'($random(seed));
    analog_result = {$random(seed), $random(seed)};
    aresetn = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(iosr_pkg::OFS_WAKE, iosr_pkg::RESP_OKAY);
    check(v, {16'h0, iosr_pkg::WAKE_RST});
    rd(8'h40, iosr_pkg::RESP_SLVERR);
    wr(iosr_pkg::OFS_CTRL, 32'h1);
    eq = {};
    for (int i = 0; i < txt.len(); i++) eq.push_back(txt[i]);
    cmp(iosr_pkg::DEST_HOST_TEXT);
    wr(iosr_pkg::OFS_PCFG_LO, 32'h953);
    wr(iosr_pkg::OFS_PCFG_HI, 32'hC0);
    check(line_out[3:2], 2'h1);
    check(line_oe_n[3:0], 4'h3);
    wr(iosr_pkg::OFS_CTRL, 32'h3);
    mk(13'h1001, 4'h2, 1);
    cmp(iosr_pkg::DEST_HOST_API);
    v = $random(seed);
    wr(iosr_pkg::OFS_DADDR_H, v);
    wr(iosr_pkg::OFS_DADDR_L, ~v);
    wr(iosr_pkg::OFS_WATCH, 32'h1);
    line_in[12] <= ~line_in[12];
    repeat (30) @(posedge aclk);
    check(p.nl, 0);
    line_in[0] <= ~line_in[0];
    @(posedge aclk);
    mk(13'h1001, 4'h2, 0);
    cmp(iosr_pkg::DEST_REMOTE);
    check(p.ad, {v, ~v});
    rd(iosr_pkg::OFS_STATUS, iosr_pkg::RESP_OKAY);
    check(v[28:16], line_in);
    wr(iosr_pkg::OFS_WATCH, 32'h0);
    wr(iosr_pkg::OFS_IVAL, 32'h5);
    repeat (1000) @(posedge aclk);
    check(p.nl inside {[9:11]}, 1);
    cmp(iosr_pkg::DEST_REMOTE);
    wr(iosr_pkg::OFS_IVAL, 32'h0);
    repeat (200) @(posedge aclk);
    p.nl = 0;
    repeat (1000) @(posedge aclk);
    check(p.nl, 0);
    wr(iosr_pkg::OFS_WAKE, 32'h2);
    wr(iosr_pkg::OFS_CTRL, 32'h6);
    wr(iosr_pkg::OFS_IVAL, 32'h1);
    repeat (100) @(posedge aclk);
    check(sleep_ok, 1);
    p.nl = 0;
    repeat (100) @(posedge aclk);
    check(p.nl, 0);
    wake_req <= 1;
    repeat (10) @(posedge aclk);
    check(sleep_ok, 0);
    repeat (60) @(posedge aclk);
    check(p.nl != 0, 1);
    p.send(8'h5A);
    repeat (10) @(posedge aclk);
    check(p.fq[0], 9'h15A);
    wr(iosr_pkg::OFS_CTRL, 32'h0);
    p.send(8'hC3);
    repeat (10) @(posedge aclk);
    check(p.fq.size(), 1);
    summarize();
  end
endmodule
`default_nettype wire
